// ==== hdl/mdts_pkg.sv ====
// constants for the motion data table store
//
// Functional notes
// - table holds entries 1 through 63
// - recompute deferred until motion stops
// - position signed 24-bit, default zero
// - speed 0 to 500000 Hz, default 1000
// - mode 0 relative, 1 absolute
// - link 0 single, 1 chain, 2 dwell
// - accel 0.001 to 1000.000 ms/kHz, default 30
// - decel same range and unit
// - sequential flag, default disabled
// - dwell 0 to 50000 ms, default zero
// - common ramp overrides per-entry ramp values
// - working copy volatile, stored copy retained
// - power-up copies store, then recomputes
// - serial writes reach working copy only
// - system settings apply after a save and a power cycle
`default_nettype none
package mdts_pkg;
  localparam int ENTRIES = 63;
  localparam int IDX_W   = 6;
  localparam int POS_W   = 24;
  localparam int SPD_W   = 19;
  localparam int LNK_W   = 2;
  localparam int RMP_W   = 20;
  localparam int DWL_W   = 16;
  localparam int DATA_W  = 24;
  localparam int SYS_W   = 16;
  localparam int POS_LSB = 0;
  localparam int SPD_LSB = POS_LSB + POS_W;
  localparam int MOD_LSB = SPD_LSB + SPD_W;
  localparam int LNK_LSB = MOD_LSB + 1;
  localparam int ACC_LSB = LNK_LSB + LNK_W;
  localparam int DEC_LSB = ACC_LSB + RMP_W;
  localparam int SEQ_LSB = DEC_LSB + RMP_W;
  localparam int DWL_LSB = SEQ_LSB + 1;
  localparam int WORD_W  = DWL_LSB + DWL_W;
  localparam logic [SPD_W-1:0] SPD_MAX = 19'h7A120;
  localparam logic [SPD_W-1:0] SPD_DEF = 19'h003E8;
  localparam logic [LNK_W-1:0] LNK_MAX = 2'h2;
  localparam logic [RMP_W-1:0] RMP_MIN = 20'h00001;
  localparam logic [RMP_W-1:0] RMP_MAX = 20'hF4240;
  localparam logic [RMP_W-1:0] RMP_DEF = 20'h07530;
  localparam logic [DWL_W-1:0] DWL_MAX = 16'hC350;
  localparam logic [2:0] F_POS = 3'h0;
  localparam logic [2:0] F_SPD = 3'h1;
  localparam logic [2:0] F_MOD = 3'h2;
  localparam logic [2:0] F_LNK = 3'h3;
  localparam logic [2:0] F_ACC = 3'h4;
  localparam logic [2:0] F_DEC = 3'h5;
  localparam logic [2:0] F_SEQ = 3'h6;
  localparam logic [2:0] F_DWL = 3'h7;
  localparam logic [WORD_W-1:0] WORD_DEF =
    {16'h0000, 1'b0, RMP_DEF, RMP_DEF, 2'h0, 1'b0, SPD_DEF, 24'h000000};
  typedef enum logic [1:0] {
    mdts_copy,
    mdts_calc,
    mdts_run
  } mdts_state_t;
endpackage
`default_nettype wire

// ==== hdl/mdts_store.sv ====
// motion profile table with working and stored parameter copies
`default_nettype none
module mdts_store #(
  parameter int N_ENTRIES = mdts_pkg::ENTRIES
) (
  input  wire logic                         clock,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  input  wire logic [5:0]                   entry_select,
  input  wire logic                         start_req,
  input  wire logic                         motor_stopped,
  input  wire logic                         ramp_common,
  input  wire logic [mdts_pkg::RMP_W-1:0]   common_accel,
  input  wire logic [mdts_pkg::RMP_W-1:0]   common_decel,
  input  wire logic                         ser_wr,
  input  wire logic [mdts_pkg::IDX_W-1:0]   ser_entry,
  input  wire logic [2:0]                   ser_field,
  input  wire logic [mdts_pkg::DATA_W-1:0]  ser_data,
  input  wire logic                         save_entry,
  input  wire logic                         restore_defaults,
  input  wire logic                         sys_wr,
  input  wire logic [mdts_pkg::SYS_W-1:0]   sys_data,
  input  wire logic                         save_sys,
  output logic                              init_done,
  output logic                              start_ok,
  output logic                              sel_valid,
  output logic                              ser_err,
  output logic signed [mdts_pkg::POS_W-1:0] act_position,
  output logic [mdts_pkg::SPD_W-1:0]        act_speed,
  output logic                              absolute_addressing,
  output logic [mdts_pkg::LNK_W-1:0]        act_link,
  output logic [mdts_pkg::RMP_W-1:0]        act_accel,
  output logic [mdts_pkg::RMP_W-1:0]        act_decel,
  output logic                              act_seq,
  output logic [mdts_pkg::DWL_W-1:0]        act_dwell,
  output logic [mdts_pkg::SYS_W-1:0]        sys_active,
  output logic [mdts_pkg::SYS_W-1:0]        sys_pending,
  output logic                              pending_changes
);
  import mdts_pkg::*;

  // elaboration checks on the layout and the table depth
  if (WORD_W != 103) begin : g_layout_check
    $error("entry word layout does not match field widths");
  end
  if (DATA_W != POS_W) begin : g_data_check
    $error("serial data width must equal the position width");
  end
  if ((N_ENTRIES < 1) || (N_ENTRIES > (1 << IDX_W) - 1)) begin : g_depth
    $error("entry count must be reachable by the select lines");
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage arrays
  logic [WORD_W-1:0] ram [1:N_ENTRIES];
  // stored copy holds factory defaults until the first save
  logic [WORD_W-1:0] nvm [1:N_ENTRIES] = '{default: WORD_DEF};
  logic [SYS_W-1:0]  nv_sys = '0;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // only the second flop of each pair feeds logic
  logic [5:0]        sel_meta;
  logic [5:0]        sel_sync;
  logic              start_meta;
  logic              start_sync;
  logic [5:0]        sel_last;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_meta   <= 6'h00;
      sel_sync   <= 6'h00;
      start_meta <= 1'b0;
      start_sync <= 1'b0;
    end else if (ce) begin
      sel_meta   <= entry_select;
      sel_sync   <= sel_meta;
      start_meta <= start_req;
      start_sync <= start_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode and checks
  mdts_state_t       state;
  logic [IDX_W-1:0]  idx;
  logic              dirty;
  wire logic         running    = (state == mdts_run);
  // entry 0 selects nothing; entry 1 is then read only as a safe address
  wire logic         sel_ok     = (sel_sync != 6'h00)
                                  && (sel_sync <= IDX_W'(N_ENTRIES));
  wire logic         ent_ok     = (ser_entry != 6'h00)
                                  && (ser_entry <= IDX_W'(N_ENTRIES));
  wire logic [WORD_W-1:0] ser_old = ram[ent_ok ? ser_entry : 6'h01];
  wire logic [WORD_W-1:0] sel_word = ram[sel_ok ? sel_sync : 6'h01];
  wire logic [SPD_W-1:0]  d_spd  = ser_data[SPD_W-1:0];
  wire logic [RMP_W-1:0]  d_rmp  = ser_data[RMP_W-1:0];
  wire logic [DWL_W-1:0]  d_dwl  = ser_data[DWL_W-1:0];
  wire logic [LNK_W-1:0]  d_lnk  = ser_data[LNK_W-1:0];
  wire logic         hi_spd = (ser_data[DATA_W-1:SPD_W] != '0);
  wire logic         hi_rmp = (ser_data[DATA_W-1:RMP_W] != '0);
  wire logic         hi_dwl = (ser_data[DATA_W-1:DWL_W] != '0);
  wire logic         hi_lnk = (ser_data[DATA_W-1:LNK_W] != '0);
  wire logic         hi_bit = (ser_data[DATA_W-1:1] != '0);
  wire logic         spd_ok = !hi_spd && (d_spd <= SPD_MAX);
  wire logic         rmp_ok = !hi_rmp && (d_rmp >= RMP_MIN)
                              && (d_rmp <= RMP_MAX);
  wire logic         lnk_ok = !hi_lnk && (d_lnk <= LNK_MAX);
  wire logic         dwl_ok = !hi_dwl && (d_dwl <= DWL_MAX);
  logic              range_ok;
  logic [WORD_W-1:0] next_word;

  always_comb begin
    range_ok  = 1'b1;
    next_word = ser_old;
    case (ser_field)
      F_POS: begin
        next_word[SPD_LSB-1:POS_LSB] = ser_data;
      end
      F_SPD: begin
        range_ok = spd_ok;
        next_word[MOD_LSB-1:SPD_LSB] = d_spd;
      end
      F_MOD: begin
        range_ok = !hi_bit;
        next_word[MOD_LSB] = ser_data[0];
      end
      F_LNK: begin
        range_ok = lnk_ok;
        next_word[ACC_LSB-1:LNK_LSB] = d_lnk;
      end
      F_ACC: begin
        range_ok = rmp_ok;
        next_word[DEC_LSB-1:ACC_LSB] = d_rmp;
      end
      F_DEC: begin
        range_ok = rmp_ok;
        next_word[SEQ_LSB-1:DEC_LSB] = d_rmp;
      end
      F_SEQ: begin
        range_ok = !hi_bit;
        next_word[SEQ_LSB] = ser_data[0];
      end
      F_DWL: begin
        range_ok = dwl_ok;
        next_word[WORD_W-1:DWL_LSB] = d_dwl;
      end
      default: begin
        range_ok = 1'b0;
      end
    endcase
  end

  wire logic wr_take  = ce && running && ser_wr && ent_ok && range_ok;
  wire logic wr_bad   = ce && running && ser_wr && !(ent_ok && range_ok);
  wire logic fill     = ce && running && restore_defaults;
  wire logic copying  = ce && (state == mdts_copy);
  wire logic recalc   = ce && running && motor_stopped
                        && (dirty || (sel_sync != sel_last));
  wire logic [IDX_W-1:0] next_idx = idx + 6'h01;

  ////////////////////////////////////////////////////////////////////////////
  // working copy: power-up load, serial writes, default fill
  for (genvar e = 1; e <= N_ENTRIES; e++) begin : g_entry
    always_ff @(posedge clock) begin
      if (copying && (idx == IDX_W'(e))) begin
        ram[e] <= nvm[e];
      end else if (fill) begin
        ram[e] <= WORD_DEF;
      end else if (wr_take && (ser_entry == IDX_W'(e))) begin
        ram[e] <= next_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // retained copy, written only on an explicit save
  // each rewrite wears the stored copy, so nothing saves on its own
  always_ff @(posedge clock) begin
    if (ce && running && save_entry && ent_ok) begin
      nvm[ser_entry] <= ram[ser_entry];
    end
    if (ce && running && save_sys) begin
      nv_sys <= sys_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequencer
  // one entry is loaded per clock, then the selected entry is applied
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state     <= mdts_copy;
      idx       <= 6'h01;
      init_done <= 1'b0;
    end else if (ce) begin
      case (state)
        mdts_copy: begin
          idx <= next_idx;
          if (idx == IDX_W'(N_ENTRIES)) begin
            state <= mdts_calc;
          end
        end
        mdts_calc: begin
          state     <= mdts_run;
          init_done <= 1'b1;
        end
        mdts_run: begin
          init_done <= 1'b1;
        end
        default: begin
          state <= mdts_copy;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending-change flag, set wins over clear
  // a write on the apply edge keeps the flag, so it is applied next
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dirty   <= 1'b0;
      ser_err <= 1'b0;
    end else if (ce) begin
      ser_err <= wr_bad;
      if (wr_take || fill) begin
        dirty <= 1'b1;
      end else if (recalc) begin
        dirty <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system settings: staged now, active after next power cycle
  // a staged value survives only through a save and a power cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sys_pending <= '0;
      sys_active  <= '0;
    end else if (ce) begin
      if (state == mdts_calc) begin
        sys_active  <= nv_sys;
        sys_pending <= nv_sys;
      end else if (running && sys_wr) begin
        sys_pending <= sys_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fields of the selected entry, ramps per the ramp-type setting
  wire logic [POS_W-1:0] sel_pos = sel_word[SPD_LSB-1:POS_LSB];
  wire logic [SPD_W-1:0] sel_spd = sel_word[MOD_LSB-1:SPD_LSB];
  wire logic             sel_abs = sel_word[MOD_LSB];
  wire logic [LNK_W-1:0] sel_lnk = sel_word[ACC_LSB-1:LNK_LSB];
  wire logic [RMP_W-1:0] sel_acc = ramp_common ? common_accel
                                   : sel_word[DEC_LSB-1:ACC_LSB];
  wire logic [RMP_W-1:0] sel_dec = ramp_common ? common_decel
                                   : sel_word[SEQ_LSB-1:DEC_LSB];
  wire logic             sel_seq = sel_word[SEQ_LSB];
  wire logic [DWL_W-1:0] sel_dwl = sel_word[WORD_W-1:DWL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // derived motion values for the selected entry
  wire logic load_act = ce && ((state == mdts_calc) || recalc);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      act_position        <= '0;
      act_speed           <= '0;
      absolute_addressing <= 1'b0;
      act_link            <= '0;
      act_accel           <= '0;
      act_decel           <= '0;
      act_seq             <= 1'b0;
      act_dwell           <= '0;
      sel_last            <= 6'h00;
    end else if (load_act) begin
      sel_last            <= sel_sync;
      act_position        <= sel_pos;
      act_speed           <= sel_spd;
      absolute_addressing <= sel_abs;
      act_link            <= sel_lnk;
      act_accel           <= sel_acc;
      act_decel           <= sel_dec;
      act_seq             <= sel_seq;
      act_dwell           <= sel_dwl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start gating and status
  // starts wait for the power-up load and for any pending change
  assign sel_valid       = sel_ok && running;
  assign start_ok        = start_sync && init_done && sel_ok
                           && !dirty;
  assign pending_changes = dirty;

endmodule
`default_nettype wire

// ==== test/mdts_monitor.sv ====
// checker for the motion profile store ports
`default_nettype none
module mdts_monitor
  import mdts_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        rstn,
  input wire logic                        motor_stopped,
  input wire logic                        ser_wr,
  input wire logic [mdts_pkg::IDX_W-1:0]  ser_entry,
  input wire logic [2:0]                  ser_field,
  input wire logic [mdts_pkg::DATA_W-1:0] ser_data,
  input wire logic                        restore_defaults,
  input wire logic                        init_done,
  input wire logic                        start_ok,
  input wire logic                        sel_valid,
  input wire logic                        ser_err,
  input wire logic [mdts_pkg::SPD_W-1:0]  act_speed,
  input wire logic [mdts_pkg::SYS_W-1:0]  sys_active,
  input wire logic                        pending_changes
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  err_cause_a: assert property (ser_err |-> $past(ser_wr && init_done))
    else $error("error pulse without a write");
  entry_zero_a: assert property (ser_wr && init_done && ser_entry == 6'h00
    |=> ser_err)
    else $error("entry zero write not refused");
  mode_range_a: assert property (ser_wr && init_done && ser_field == F_MOD
    && ser_data > 24'h000001 |=> ser_err)
    else $error("bad mode value not refused");
  start_gate_a: assert property (start_ok |-> init_done && !pending_changes)
    else $error("start allowed too early");
  sel_gate_a: assert property (sel_valid |-> init_done)
    else $error("selection valid before load");
  hold_moving_a: assert property (init_done && !motor_stopped
    |=> $stable(act_speed))
    else $error("applied speed changed in motion");
  sys_hold_a: assert property (init_done |=> $stable(sys_active))
    else $error("system setting changed at run time");
  dirty_clear_a: assert property (pending_changes && motor_stopped && !ser_wr
    && !restore_defaults |=> !pending_changes)
    else $error("pending changes not applied at stop");
endmodule
`default_nettype wire

// ==== test/mdts_host.sv ====
// host model: serial writes and entry selection pins
`default_nettype none
module mdts_host (
  input  wire logic        clock,
  output logic             ser_wr,
  output logic [5:0]       ser_entry,
  output logic [2:0]       ser_field,
  output logic [23:0]      ser_data,
  output logic             save_entry,
  output logic [5:0]       entry_select,
  output logic             start_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {ser_wr, ser_entry, ser_field, ser_data, save_entry} = '0;
    {entry_select, start_req} = '0;
  end
  // one field per write, or a save of one entry
  task automatic wr(input logic [5:0] e, input logic [2:0] f,
                    input logic [23:0] d, input logic sv);
    @(posedge clock);
    #1;
    {ser_entry, ser_field, ser_data} = {e, f, d};
    if (sv) save_entry = 1'b1;
    else ser_wr = 1'b1;
    @(posedge clock);
    #1;
    {ser_wr, save_entry} = 2'h0;
    ser_data = ~d;
  endtask
  // entry number in binary, bit0 least significant
  task automatic sel(input logic [5:0] e, input logic s);
    entry_select = e;
    start_req = s;
  endtask
endmodule
`default_nettype wire

// ==== test/mdts_store_bench.sv ====
// self-checking bench for the motion profile store
`default_nettype none
module mdts_store_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mdts_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, ce = 1'b1, motor_stopped = 1'b1;
  logic ramp_common = 1'b0, restore_defaults = 1'b0;
  logic sys_wr = 1'b0, save_sys = 1'b0;
  logic [RMP_W-1:0] common_accel = '0, common_decel = '0;
  logic [SYS_W-1:0] sys_data = '0, sys_active, sys_pending;
  logic ser_wr, save_entry, start_req, init_done, start_ok, sel_valid;
  logic ser_err, absolute_addressing, act_seq, pending_changes;
  logic [5:0] ser_entry, entry_select;
  logic [2:0] ser_field;
  logic [23:0] ser_data;
  logic signed [POS_W-1:0] act_position;
  logic [SPD_W-1:0] act_speed;
  logic [LNK_W-1:0] act_link;
  logic [RMP_W-1:0] act_accel, act_decel;
  logic [DWL_W-1:0] act_dwell;
  logic [23:0] dflt [8], good [8], bad [8];
  int n_fail = 0, checks_done = 0;
  always #50 clock = ~clock;
  mdts_host i_host (.clock, .ser_wr, .ser_entry, .ser_field, .ser_data,
    .save_entry, .entry_select, .start_req);
  mdts_store i_dut (.clock, .rstn, .ce, .entry_select, .start_req,
    .motor_stopped, .ramp_common, .common_accel, .common_decel, .ser_wr,
    .ser_entry, .ser_field, .ser_data, .save_entry, .restore_defaults,
    .sys_wr, .sys_data, .save_sys, .init_done, .start_ok, .sel_valid,
    .ser_err, .act_position, .act_speed, .absolute_addressing, .act_link,
    .act_accel, .act_decel, .act_seq, .act_dwell, .sys_active,
    .sys_pending, .pending_changes);
  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_all(input logic [23:0] e [8]);
    logic [23:0] g [8];
    g = '{24'(act_position), 24'(act_speed), 24'(absolute_addressing),
      24'(act_link), 24'(act_accel), 24'(act_decel), 24'(act_seq),
      24'(act_dwell)};
    foreach (g[k]) chk($sformatf("field %0d", k), e[k], g[k]);
  endtask
  task automatic power_cycle();
    step(1);
    rstn = 1'b0;
    step(12);
    chk("init_done", 24'h0, 24'(init_done));
    rstn = 1'b1;
    for (int i = 0; i < 200 && init_done !== 1'b1; i++) begin
      chk("start_ok", 24'h0, 24'(start_ok));
      step(1);
    end
    chk("init_done", 24'h1, 24'(init_done));
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    i_host.sel(6'h05, 1'b1);
    i_host.wr(6'h05, F_DWL, 24'h000007, 1'b0);
    step(2);
    chk("sel_valid", 24'h1, 24'(sel_valid));
    chk("dwell", 24'h000007, 24'(act_dwell));
    restore_defaults = 1'b1;
    step(1);
    restore_defaults = 1'b0;
    step(6);
    chk_all(dflt);
  endtask
  task automatic t_write();
    motor_stopped = 1'b0;
    for (int f = 0; f < 8; f++) i_host.wr(6'h05, 3'(f), good[f], 1'b0);
    chk("pending", 24'h1, 24'(pending_changes));
    chk("start_ok", 24'h0, 24'(start_ok));
    chk_all(dflt);
    motor_stopped = 1'b1;
    step(3);
    chk_all(good);
  endtask
  task automatic t_refuse();
    i_host.wr(6'h00, F_SPD, 24'h000001, 1'b0);
    chk("ser_err", 24'h1, 24'(ser_err));
    for (int f = 1; f < 8; f++) begin
      i_host.wr(6'h05, 3'(f), bad[f], 1'b0);
      chk("ser_err", 24'h1, 24'(ser_err));
    end
    step(3);
    chk_all(good);
  endtask
  task automatic t_common();
    ramp_common = 1'b1;
    common_accel = 20'h00064;
    common_decel = 20'h000C8;
    i_host.wr(6'h05, F_SEQ, 24'h000001, 1'b0);
    step(3);
    chk("accel", 24'h000064, 24'(act_accel));
    chk("decel", 24'h0000C8, 24'(act_decel));
    ramp_common = 1'b0;
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    i_host.wr(6'h05, F_SPD, 24'h000200, 1'b0);
    step(3);
    chk("pending", 24'h0, 24'(pending_changes));
    chk("speed", 24'(SPD_MAX), 24'(act_speed));
    ce = 1'b1;
    step(3);
    chk("speed", 24'(SPD_MAX), 24'(act_speed));
  endtask
  task automatic t_store();
    i_host.wr(6'h05, F_POS, 24'h000000, 1'b1);
    sys_data = 16'h1234;
    sys_wr = 1'b1;
    step(1);
    sys_wr = 1'b0;
    save_sys = 1'b1;
    step(1);
    save_sys = 1'b0;
    chk("sys_pending", 24'h001234, 24'(sys_pending));
    chk("sys_active", 24'h000000, 24'(sys_active));
    i_host.wr(6'h05, F_SPD, 24'h000100, 1'b0);
    step(3);
    chk("speed", 24'h000100, 24'(act_speed));
    power_cycle();
    step(6);
    chk("speed", 24'(SPD_MAX), 24'(act_speed));
    chk("sys_active", 24'h001234, 24'(sys_active));
    chk("start_ok", 24'h1, 24'(start_ok));
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    dflt = '{24'h0, 24'(SPD_DEF), 24'h0, 24'h0, 24'(RMP_DEF), 24'(RMP_DEF),
      24'h0, 24'h0};
    good = '{24'h800000, 24'(SPD_MAX), 24'h1, 24'h2, 24'(RMP_MAX),
      24'(RMP_MIN), 24'h1, 24'(DWL_MAX)};
    bad = '{24'h0, 24'h07A121, 24'h2, 24'h3, 24'h0, 24'h0F4241, 24'h2,
      24'h00C351};
    power_cycle();
    t_defaults();
    t_write();
    t_refuse();
    t_common();
    t_freeze();
    t_store();
    end_of_test();
  end
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule
bind mdts_store mdts_monitor i_mon (.clock, .rstn, .motor_stopped, .ser_wr,
  .ser_entry, .ser_field, .ser_data, .restore_defaults, .init_done,
  .start_ok, .sel_valid, .ser_err, .act_speed, .sys_active,
  .pending_changes);
`default_nettype wire
